// ==== rtc_core.sv ====
`timescale 1ns/100ps
// ******************************************************************
// seconds clock with match and retained storage
// ******************************************************************
// Functional notes
// (RULE_01) seconds advance once per 32768 clock cycles
// (RULE_02) 32-bit up-counter increments each second
// (RULE_03) 32-bit down-counter starts at all ones
// (RULE_04) two match registers, writable and readable
// (RULE_05) enabled match raises interrupt request
// (RULE_06) match can assert power-on request pin
// (RULE_07) match alarm can wake from stop
// (RULE_08) 32-word retained storage array
// (RULE_09) slow clock exported to other blocks
// (RULE_10) down-counter decrements per second, both wrap
// (RULE_11) per-match sticky flags, compared each tick
module rtc_core
  import rtc_pkg::*;
(
  // clock and reset (clock is the slow oscillator)
  input wire logic clk_sys,
  input wire logic reset_n,
  // counter preload
  input wire logic up_load,
  input wire logic [count_width-1:0] up_load_value,
  input wire logic down_load,
  input wire logic [count_width-1:0] down_load_value,
  // match registers
  input wire logic [match_count-1:0] match_wr,
  input wire logic [count_width-1:0] match_wdata,
  input wire logic [match_count-1:0] match_irq_enable,
  input wire logic [match_count-1:0] match_wake_enable,
  input wire logic [match_count-1:0] match_power_enable,
  input wire logic [match_count-1:0] match_flag_clear,
  input wire logic power_request_clear,
  // retained storage port
  input wire logic ram_wr,
  input wire logic [ram_addr_width-1:0] ram_addr,
  input wire logic [count_width-1:0] ram_wdata,
  output logic [count_width-1:0] ram_rdata,
  // status
  output logic [count_width-1:0] up_count,
  output logic [count_width-1:0] down_count,
  output logic [count_width-1:0] match_value0,
  output logic [count_width-1:0] match_value1,
  output logic [match_count-1:0] match_flag,
  output logic second_tick,
  // events
  output logic irq,
  output logic stop_wake,
  output logic power_on_request_out,
  output logic slow_oscillator_clock
);
  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta;  // first stage
  logic rst_sync;  // released reset, active low (1 once reset is released)

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire rst_n_int = rst_sync;  // internal active-low reset

  // ****************************************************************
  // seconds prescaler
  // ****************************************************************
  logic [tick_width-1:0] prescale;  // sub-second count
  wire tick_now = (prescale == tick_last);  // last cycle of second

  // count oscillator cycles within a second
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;  // wraps at 32768 [RULE_01]
    end
  end

  // ****************************************************************
  // seconds counters
  // ****************************************************************
  wire [count_width-1:0] next_up = up_load ? up_load_value :
    (tick_now ? up_count + 1'b1 : up_count);  // [RULE_02] [RULE_10]
  wire [count_width-1:0] next_down = down_load ? down_load_value :
    (tick_now ? down_count - 1'b1 : down_count);  // [RULE_10]

  // counter registers
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      up_count <= up_reset;
      down_count <= down_reset;  // all ones [RULE_03]
      second_tick <= 1'b0;
    end else begin
      up_count <= next_up;
      down_count <= next_down;
      second_tick <= tick_now;
    end
  end

  // ****************************************************************
  // match registers and flags
  // ****************************************************************
  logic [count_width-1:0] match_reg [match_count];  // match values
  logic [match_count-1:0] hit;  // compare at tick

  genvar i;
  generate
    for (i = 0; i < match_count; i++) begin : g_match
      // compare new count once per second [RULE_11]
      assign hit[i] = tick_now && (next_up == match_reg[i]);
      // match value and sticky flag, set beats clear
      always_ff @(posedge clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
          match_reg[i] <= match_reset;
          match_flag[i] <= 1'b0;
        end else begin
          if (match_wr[i]) begin
            match_reg[i] <= match_wdata;  // [RULE_04]
          end
          match_flag[i] <= hit[i] | (match_flag[i] & ~match_flag_clear[i]);
        end
      end
    end
  endgenerate

  assign match_value0 = match_reg[0];  // read back [RULE_04]
  assign match_value1 = match_reg[1];
  assign irq = |(match_flag & match_irq_enable);  // [RULE_05]
  assign stop_wake = |(match_flag & match_wake_enable);  // [RULE_07]

  // ****************************************************************
  // power-on request pin
  // ****************************************************************
  wire power_set = |(hit & match_power_enable);  // match event

  // held until cleared, set wins
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      power_on_request_out <= 1'b0;
    end else begin
      power_on_request_out <= power_set |
        (power_on_request_out & ~power_request_clear);  // [RULE_06]
    end
  end

  // ****************************************************************
  // retained storage and clock export
  // ****************************************************************
  rtc_ram_if ram_bus ();
  assign ram_bus.wr_en = ram_wr;
  assign ram_bus.addr = ram_addr;
  assign ram_bus.wdata = ram_wdata;
  assign ram_rdata = ram_bus.rdata;

  // storage array [RULE_08]
  rtc_ram u_ram (
    .clk_sys(clk_sys),
    .bus(ram_bus)
  );

  assign slow_oscillator_clock = clk_sys;  // export [RULE_09]

  // ****************************************************************
  // checks
  // ****************************************************************
  // prescaler is back at zero when the second pulse shows
  a_tick_period: assert property (@(posedge clk_sys)  // [RULE_01]
    disable iff (!rst_n_int) second_tick |-> prescale == '0)
    else $error("tick not at second boundary");
  // up-counter steps by one on a tick, wrapping silently
  a_up_step: assert property (@(posedge clk_sys)  // [RULE_02]
    disable iff (!rst_n_int)
    (tick_now && !up_load) |=> up_count == $past(up_count) + 1'b1)
    else $error("up count did not step");
  // up-counter holds between ticks
  a_up_hold: assert property (@(posedge clk_sys)  // [RULE_10]
    disable iff (!rst_n_int)
    (!tick_now && !up_load) |=> $stable(up_count))
    else $error("up count moved off tick");
  // down-counter steps down on the same tick
  a_down_step: assert property (@(posedge clk_sys)  // [RULE_10]
    disable iff (!rst_n_int)
    (tick_now && !down_load) |=> down_count == $past(down_count) - 1'b1)
    else $error("down count did not step");
  // down-counter holds between ticks
  a_down_hold: assert property (@(posedge clk_sys)  // [RULE_10]
    disable iff (!rst_n_int)
    (!tick_now && !down_load) |=> $stable(down_count))
    else $error("down count moved off tick");
  // down-counter leaves reset with every bit set
  a_down_init: assert property (@(posedge clk_sys)  // [RULE_03]
    $rose(rst_n_int) |-> down_count == down_reset)
    else $error("down count not all ones");
  // first match register takes its write
  a_match_wr: assert property (@(posedge clk_sys)  // [RULE_04]
    disable iff (!rst_n_int)
    match_wr[0] |=> match_value0 == $past(match_wdata))
    else $error("match write lost");
  // second match register takes its write
  a_second_match_wr: assert property (@(posedge clk_sys)  // [RULE_04]
    disable iff (!rst_n_int)
    match_wr[1] |=> match_value1 == $past(match_wdata))
    else $error("second match write lost");
  // a hit latches its flag
  a_flag_set: assert property (@(posedge clk_sys)  // [RULE_11]
    disable iff (!rst_n_int)
    hit[0] |=> match_flag[0])
    else $error("match flag not set");
  // a clear without a new hit drops the flag
  a_flag_clear: assert property (@(posedge clk_sys)  // [RULE_11]
    disable iff (!rst_n_int)
    (match_flag_clear[0] && !hit[0]) |=> !match_flag[0])
    else $error("match flag not cleared");
  // enabled flag reaches the interrupt line
  a_irq_gate: assert property (@(posedge clk_sys)  // [RULE_05]
    disable iff (!rst_n_int)
    (match_flag[0] && match_irq_enable[0]) |-> irq)
    else $error("enabled match without interrupt");
  // with flag 0 clear and match 1 interrupt masked, the interrupt line stays low
  a_irq_mask: assert property (@(posedge clk_sys)  // [RULE_05]
    disable iff (!rst_n_int)
    (!match_flag[0] && !match_irq_enable[1]) |-> !irq)
    else $error("masked interrupt asserted");
  // enabled flag reaches the wake line
  a_wake_gate: assert property (@(posedge clk_sys)  // [RULE_07]
    disable iff (!rst_n_int)
    (match_flag[1] && match_wake_enable[1]) |-> stop_wake)
    else $error("no wake on match");
  // enabled hit raises the power request pin
  a_power_set: assert property (@(posedge clk_sys)  // [RULE_06]
    disable iff (!rst_n_int)
    power_set |=> power_on_request_out)
    else $error("power request not raised");
  // a written word reads back one cycle after its address
  a_ram_read: assert property (@(posedge clk_sys)  // [RULE_08]
    disable iff (!rst_n_int)
    (ram_wr ##1 !ram_wr && ram_addr == $past(ram_addr))
      |=> ram_rdata == $past(ram_wdata, 2))
    else $error("storage readback wrong");
  c_tick: cover property (@(posedge clk_sys) second_tick);
  c_match: cover property (@(posedge clk_sys) hit[0]);
  c_power: cover property (@(posedge clk_sys) power_on_request_out);
endmodule

// ==== rtc_core_test.sv ====
`timescale 1ns/100ps
module rtc_core_test;
  import rtc_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic clk_sys = 0;  // slow oscillator stand-in
  logic reset_n = 0;  // active low reset
  logic up_load = 0, down_load = 0, power_request_clear = 0, ram_wr = 0;
  logic [31:0] up_load_value = '0, down_load_value = '0;
  logic [31:0] match_wdata = '0, ram_wdata = '0;
  logic [1:0] match_wr = '0, match_irq_enable = '0;
  logic [1:0] match_wake_enable = '0, match_power_enable = '0;
  logic [1:0] match_flag_clear = '0;
  logic [4:0] ram_addr = '0;
  logic [31:0] ram_rdata, up_count, down_count, match_value0, match_value1;
  logic [1:0] match_flag;
  logic second_tick, irq, stop_wake, power_on_request_out;
  logic slow_oscillator_clock;
  int bad_count = 0, n_tests = 0, cyc = 0, t1 = 0;
  // storage table rows: address and the word it should hold
  typedef struct {logic [4:0] addr; logic [31:0] data;} row_t;
  row_t rows[4] = '{'{5'h00, 32'hdead_beef}, '{5'h1f, 32'h0123_4567},
                    '{5'h0a, 32'hffff_ffff}, '{5'h01, 32'h0000_0000}};
  rtc_core uut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .up_load(up_load),
    .up_load_value(up_load_value),
    .down_load(down_load),
    .down_load_value(down_load_value),
    .match_wr(match_wr),
    .match_wdata(match_wdata),
    .match_irq_enable(match_irq_enable),
    .match_wake_enable(match_wake_enable),
    .match_power_enable(match_power_enable),
    .match_flag_clear(match_flag_clear),
    .power_request_clear(power_request_clear),
    .ram_wr(ram_wr),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata),
    .up_count(up_count),
    .down_count(down_count),
    .match_value0(match_value0),
    .match_value1(match_value1),
    .match_flag(match_flag),
    .second_tick(second_tick),
    .irq(irq),
    .stop_wake(stop_wake),
    .power_on_request_out(power_on_request_out),
    .slow_oscillator_clock(slow_oscillator_clock)
  );
  // ****************************************************************
  // clock, cycle count and watchdog
  // ****************************************************************
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  initial begin
    // two seconds of slow clock plus margin
    #(80000 * 20);
    bad_count++;
    end_of_test;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wait_tick;
    int n;
    n = 0;
    // bounded wait, a little over one second of slow clock
    while (second_tick !== 1'b1 && n < 33000) begin
      step;
      n++;
    end
    // a limit that runs out counts as a mismatch
    check("tick seen", second_tick, 1'b1);
  endtask
  task end_of_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    step;
    step;
    reset_n = 1;
    check("up_count", up_count, up_reset);
    check("down_count", down_count, down_reset);
    check("match_value0", match_value0, match_reset);
    check("events", {irq, stop_wake, power_on_request_out}, 0);
    check("match_flag", match_flag, 0);
    repeat (3) step;
    // table loop: write each row, then read the same word back
    foreach (rows[i]) begin
      ram_addr = rows[i].addr;
      ram_wdata = rows[i].data;
      ram_wr = 1;
      step;
      ram_wr = 0;
      step;
      check("ram_rdata", ram_rdata, rows[i].data);
    end
    // exported clock follows the oscillator in both phases
    check("slow clock high", slow_oscillator_clock, 1'b1);
    #10;
    check("slow clock low", slow_oscillator_clock, 1'b0);
    // back to back match writes, then read back
    match_wdata = 32'h0000_1234;
    match_wr = 2'b01;
    step;
    match_wdata = 32'h0000_5678;
    match_wr = 2'b10;
    step;
    match_wr = 2'b00;
    check("match_value0", match_value0, 32'h0000_1234);
    check("match_value1", match_value1, 32'h0000_5678);
    // one second before match 0; irq and power for 0, wake for 1
    up_load_value = 32'h0000_1233;
    up_load = 1;
    match_irq_enable = 2'b01;
    match_wake_enable = 2'b10;
    match_power_enable = 2'b01;
    step;
    up_load = 0;
    check("up_load", up_count, 32'h0000_1233);
    wait_tick;
    t1 = cyc;
    check("up_count tick", up_count, 32'h0000_1234);
    check("down_count tick", down_count, 32'hffff_fffe);
    check("match_flag hit", match_flag, 2'b01);
    check("irq hit", irq, 1'b1);
    check("power hit", power_on_request_out, 1'b1);
    check("wake masked", stop_wake, 1'b0);
    step;
    check("tick pulse", second_tick, 1'b0);
    // clear the flag; the power request stays until its own clear
    match_flag_clear = 2'b01;
    step;
    match_flag_clear = 2'b00;
    check("flag cleared", match_flag, 2'b00);
    check("irq cleared", irq, 1'b0);
    check("power held", power_on_request_out, 1'b1);
    power_request_clear = 1;
    step;
    power_request_clear = 0;
    check("power cleared", power_on_request_out, 1'b0);
    // both counters at their limits, match 1 at the wrapped value
    up_load_value = 32'hffff_ffff;
    up_load = 1;
    down_load_value = 32'h0000_0000;
    down_load = 1;
    match_wdata = 32'h0000_0000;
    match_wr = 2'b10;
    step;
    up_load = 0;
    down_load = 0;
    match_wr = 2'b00;
    wait_tick;
    check("second length", cyc - t1, 32'd32768);
    check("up wrap", up_count, 32'h0000_0000);
    check("down wrap", down_count, 32'hffff_ffff);
    check("match_flag wrap", match_flag, 2'b10);
    check("wake hit", stop_wake, 1'b1);
    check("irq masked", irq, 1'b0);
    check("power masked", power_on_request_out, 1'b0);
    // mid-run reset: state returns, storage keeps its words
    ram_addr = rows[0].addr;
    reset_n = 0;
    step;
    check("reset up", up_count, up_reset);
    check("reset down", down_count, down_reset);
    check("reset match", match_value1, match_reset);
    check("reset flags", {match_flag, stop_wake, irq}, 0);
    check("reset power", power_on_request_out, 1'b0);
    check("ram kept", ram_rdata, rows[0].data);
    reset_n = 1;
    repeat (2) step;
    check("held after release", up_count, up_reset);
    end_of_test;
  end
endmodule

// ==== rtc_pkg.sv ====
package rtc_pkg;
  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int count_width = 32;  // seconds counters
  localparam int match_count = 2;  // number of match registers
  localparam int ram_words = 32;  // retained storage depth
  localparam int ram_addr_width = 5;  // storage address width
  localparam int osc_hz = 32768;  // slow oscillator rate
  localparam int tick_width = 15;  // prescaler width
  localparam logic [14:0] tick_last = 15'h7fff;  // last prescaler count
  localparam logic [31:0] up_reset = 32'h0000_0000;  // up-counter reset
  localparam logic [31:0] down_reset = 32'hffff_ffff;  // all ones
  localparam logic [31:0] match_reset = 32'hffff_ffff;  // match reset
endpackage

// ==== rtc_ram.sv ====
`timescale 1ns/100ps
// ******************************************************************
// retained storage array
// ******************************************************************
module rtc_ram
  import rtc_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // access
  rtc_ram_if.mem bus
);
  logic [count_width-1:0] store [ram_words];  // 32 words, 128 bytes

  // write then registered read
  always_ff @(posedge clk_sys) begin
    if (bus.wr_en) begin
      store[bus.addr] <= bus.wdata;
    end
    bus.rdata <= store[bus.addr];
  end
endmodule

// ==== rtc_ram_if.sv ====
`timescale 1ns/100ps
// ******************************************************************
// storage access bundle
// ******************************************************************
interface rtc_ram_if;
  import rtc_pkg::*;
  logic wr_en;  // write strobe
  logic [ram_addr_width-1:0] addr;  // word address
  logic [count_width-1:0] wdata;  // write data
  logic [count_width-1:0] rdata;  // registered read data
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
